// File: logic/aps_defs.svh
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH
// Behaviour
// - Front end yields a fresh raw angle code once every 1 us.
// - Raw codes pass a first-order low-pass; filter window sets its time constant.
// - Idle powers down front end and filter; register and angle port stay live.
// - Default settings report an angle rising with clockwise field rotation.
// - Counting direction and zero reference are software configurable.
// - Active mode runs front end and filter continuously.
// - Auto duty cycle mode alternates between active and idle on its own.
// - Low-power tick times each cycle from active-time and cycle-period registers.
// - In register-set auto duty cycle mode the host may read at any moment.
// - Auto duty cycle refresh rate equals the cycle period setting while the active time is below it.
// - Auto duty cycle mode publishes the angle only when an active period ends.
// - Enable and auto duty cycle pins select any of the three power modes.
// - Electrical angle wraps once per pole pair; no mechanical rescaling.
// - Configured power mode starts only after chip select is seen high.

`define APS_CLK_MHZ 40
`define APS_SAMPLE_NS 1000
`define APS_SAMPLE_CYC ((`APS_SAMPLE_NS * `APS_CLK_MHZ) / 1000)
`define APS_LP_TICK_NS 10000
`define APS_LP_TICK_CYC ((`APS_LP_TICK_NS * `APS_CLK_MHZ) / 1000)

`define APS_ADDR_CTRL 12'h000
`define APS_ADDR_FILT 12'h004
`define APS_ADDR_ZERO 12'h008
`define APS_ADDR_ACTIVE 12'h00c
`define APS_ADDR_CYCLE 12'h010
`define APS_ADDR_STATUS 12'h014
`define APS_ADDR_ANGLE 12'h018

`define APS_CTRL_MODE_LSB 0
`define APS_CTRL_PIN_BIT 2
`define APS_CTRL_DIR_BIT 3

`define APS_RST_MODE 2'h0
`define APS_RST_FILT 4'h4
`define APS_RST_ZERO 16'h0000
`define APS_RST_ACTIVE 8'h01
`define APS_RST_CYCLE 8'h0a
`define APS_FIFO_DEPTH 8
`endif

// File: logic/aps_pkg.sv
package aps_pkg;
    typedef enum logic [1:0] {
        APS_MODE_ACTIVE = 2'h0,
        APS_MODE_IDLE = 2'h1,
        APS_MODE_AUTO = 2'h2
    } aps_mode_t;
    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_IDLE = 5'h02,
        ST_ACTIVE = 5'h04,
        ST_AUTO_ON = 5'h08,
        ST_AUTO_OFF = 5'h10
    } aps_state_t;
endpackage

// File: logic/aps_core.sv
`include "aps_defs.svh"

module aps_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign in_ready = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module aps_core
    import aps_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EN_PIN,
    input wire logic AUTO_DUTY_CYCLE_MODE,
    input wire logic CS_N,
    output logic FE_POWER_ON,
    output logic FE_SAMPLE,
    input wire logic [15:0] RAW_ANGLE,
    input wire logic RAW_VALID,
    output logic RAW_READY,
    output logic [15:0] ANGLE,
    output logic ANGLE_UPDATE
);
    logic [1:0] mode_sel;
    logic pin_ctrl;
    logic dir_reverse;
    logic [3:0] filter_window_setting;
    logic [15:0] zero_ref;
    logic [7:0] active_time;
    logic [7:0] cycle_period_setting;
    aps_state_t state;
    aps_state_t next_state;
    aps_mode_t req_mode;
    logic started;
    logic [5:0] sample_cnt;
    logic [8:0] lp_cnt;
    logic lp_tick;
    logic [7:0] cyc_cnt;
    logic powered;
    logic [15:0] fifo_data;
    logic fifo_valid;
    logic [23:0] acc;
    logic [23:0] diff;
    logic filt_upd;
    logic filt_done;
    logic [15:0] rel_angle;
    logic [15:0] out_angle;
    logic publish;
    logic pending;
    logic [15:0] pend_angle;
    logic setup;
    logic wr_en;
    logic addr_ok;

    // Bus: every register answers in the access cycle, no wait states
    assign setup = PSEL && !PENABLE;
    // Writes land on the completing access edge, never on the setup edge
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;

    always_comb begin
        unique case (PADDR)
            `APS_ADDR_CTRL, `APS_ADDR_FILT, `APS_ADDR_ZERO, `APS_ADDR_ACTIVE,
            `APS_ADDR_CYCLE, `APS_ADDR_STATUS, `APS_ADDR_ANGLE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_sel <= `APS_RST_MODE;
            pin_ctrl <= 1'b0;
            dir_reverse <= 1'b0;
            filter_window_setting <= `APS_RST_FILT;
            zero_ref <= `APS_RST_ZERO;
            active_time <= `APS_RST_ACTIVE;
            cycle_period_setting <= `APS_RST_CYCLE;
        end else if (wr_en) begin
            unique case (PADDR)
                `APS_ADDR_CTRL: begin
                    mode_sel <= PWDATA[`APS_CTRL_MODE_LSB +: 2];
                    pin_ctrl <= PWDATA[`APS_CTRL_PIN_BIT];
                    dir_reverse <= PWDATA[`APS_CTRL_DIR_BIT];
                end
                `APS_ADDR_FILT: filter_window_setting <= PWDATA[3:0];
                `APS_ADDR_ZERO: zero_ref <= PWDATA[15:0];
                // A zero active time would wrap the compare to 255 and keep the front end on for 256 ticks; clamp to one tick
                `APS_ADDR_ACTIVE: active_time <= (PWDATA[7:0] == 8'h00) ? 8'h01 : PWDATA[7:0];
                `APS_ADDR_CYCLE: cycle_period_setting <= (PWDATA[7:0] == 8'h00) ? 8'h01 : PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle so PRDATA comes from flops
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PSLVERR <= !addr_ok;
            PRDATA <= 32'h0000_0000;
            if (!PWRITE) begin
                unique case (PADDR)
                    `APS_ADDR_CTRL: PRDATA <= {28'h0, dir_reverse, pin_ctrl, mode_sel};
                    `APS_ADDR_FILT: PRDATA <= {28'h0, filter_window_setting};
                    `APS_ADDR_ZERO: PRDATA <= {16'h0, zero_ref};
                    `APS_ADDR_ACTIVE: PRDATA <= {24'h0, active_time};
                    `APS_ADDR_CYCLE: PRDATA <= {24'h0, cycle_period_setting};
                    `APS_ADDR_STATUS: PRDATA <= {25'h0, started, powered, state};
                    `APS_ADDR_ANGLE: PRDATA <= {16'h0, ANGLE};
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pins override the register mode when pin control is on
    always_comb begin
        if (pin_ctrl) begin
            if (!EN_PIN) begin
                req_mode = APS_MODE_IDLE;
            end else if (AUTO_DUTY_CYCLE_MODE) begin
                req_mode = APS_MODE_AUTO;
            end else begin
                req_mode = APS_MODE_ACTIVE;
            end
        end else begin
            unique case (mode_sel)
                2'h0: req_mode = APS_MODE_ACTIVE;
                2'h1: req_mode = APS_MODE_IDLE;
                default: req_mode = APS_MODE_AUTO;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            started <= 1'b0;
        end else if (CS_N) begin
            started <= 1'b1;
        end
    end

    // Free-running low-power tick; never gated so cycle timing stays regular
    assign lp_tick = (lp_cnt == 9'(`APS_LP_TICK_CYC - 1));

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_cnt <= '0;
        end else begin
            lp_cnt <= lp_tick ? '0 : lp_cnt + 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: begin
                if (started) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE, ST_ACTIVE: begin
                if (req_mode == APS_MODE_ACTIVE) begin
                    next_state = ST_ACTIVE;
                end else if (req_mode == APS_MODE_AUTO) begin
                    next_state = ST_AUTO_ON;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_AUTO_ON: begin
                if (req_mode != APS_MODE_AUTO) begin
                    next_state = ST_IDLE;
                end else if (lp_tick && cyc_cnt == active_time - 8'h01) begin
                    next_state = ST_AUTO_OFF;
                end
            end
            ST_AUTO_OFF: begin
                if (req_mode != APS_MODE_AUTO) begin
                    next_state = ST_IDLE;
                end else if (lp_tick && cyc_cnt >= cycle_period_setting - 8'h01) begin
                    next_state = ST_AUTO_ON;
                end
            end
            default: next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Cycle position in low-power ticks; one full cycle is cycle_period_setting ticks while active_time is below it
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cyc_cnt <= '0;
        end else if (next_state != ST_AUTO_ON && next_state != ST_AUTO_OFF) begin
            cyc_cnt <= '0;
        end else if (state == ST_AUTO_OFF && next_state == ST_AUTO_ON) begin
            cyc_cnt <= '0;
        end else if (lp_tick && (state == ST_AUTO_ON || state == ST_AUTO_OFF)) begin
            cyc_cnt <= cyc_cnt + 8'h01;
        end
    end

    assign powered = (state == ST_ACTIVE) || (state == ST_AUTO_ON);
    assign FE_POWER_ON = powered;

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sample_cnt <= '0;
            FE_SAMPLE <= 1'b0;
        end else if (!powered) begin
            sample_cnt <= '0;
            FE_SAMPLE <= 1'b0;
        end else begin
            FE_SAMPLE <= (sample_cnt == 6'(`APS_SAMPLE_CYC - 1));
            sample_cnt <= (sample_cnt == 6'(`APS_SAMPLE_CYC - 1)) ? '0 : sample_cnt + 1'b1;
        end
    end

    // The filter drains only while powered, so an idle phase backs samples up here
    aps_fifo #(
        .WIDTH(16),
        .DEPTH(`APS_FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .in_data(RAW_ANGLE),
        .in_valid(RAW_VALID),
        .in_ready(RAW_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(powered)
    );

    // Wrapping difference keeps the filter correct across the 0/full-scale seam
    assign diff = {fifo_data, 8'h00} - acc;
    assign filt_upd = fifo_valid && powered;

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc <= '0;
        end else if (filt_upd) begin
            acc <= acc + 24'($signed(diff) >>> filter_window_setting);
        end
    end

    // Default: no reversal and zero offset, so angle follows the raw clockwise code
    assign rel_angle = acc[23:8] - zero_ref;
    assign out_angle = dir_reverse ? 16'h0000 - rel_angle : rel_angle;

    // Publish one cycle after the filter step so the fresh value, not the old one, is offered
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            filt_done <= 1'b0;
        end else begin
            filt_done <= filt_upd && (state == ST_ACTIVE);
        end
    end

    // A step finishing just as auto mode starts is left to the end of the active period
    assign publish = (filt_done && state != ST_AUTO_ON)
        || (state == ST_AUTO_ON && next_state == ST_AUTO_OFF);

    // Output holds while chip select is low; a late update waits here for its release
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pending <= 1'b0;
            pend_angle <= '0;
        end else if (publish && !CS_N) begin
            pending <= 1'b1;
            pend_angle <= out_angle;
        end else if (CS_N) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ANGLE <= '0;
            ANGLE_UPDATE <= 1'b0;
        end else begin
            ANGLE_UPDATE <= CS_N && (publish || pending);
            if (CS_N && publish) begin
                ANGLE <= out_angle;
            end else if (CS_N && pending) begin
                ANGLE <= pend_angle;
            end
            // Otherwise the last published angle simply stays offered
        end
    end
endmodule

// File: tb/aps_core_props.sv
module aps_core_props (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CS_N,
    input wire logic FE_POWER_ON,
    input wire logic FE_SAMPLE,
    input wire logic RAW_READY,
    input wire logic [15:0] ANGLE,
    input wire logic ANGLE_UPDATE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen;
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            seen <= 1'b0;
        else if (CS_N)
            seen <= 1'b1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    property p_gap; FE_SAMPLE |=> !FE_SAMPLE [*8]; endproperty
    a_gap: assert property (p_gap) else $error("sample pulses too close");
    property p_off; !FE_POWER_ON && $past(!FE_POWER_ON) |-> !FE_SAMPLE; endproperty
    a_off: assert property (p_off) else $error("sampling while unpowered");
    property p_hold; !ANGLE_UPDATE |-> $stable(ANGLE); endproperty
    a_hold: assert property (p_hold) else $error("angle moved without update");
    property p_freeze; $past(!CS_N) |-> $stable(ANGLE); endproperty
    a_freeze: assert property (p_freeze) else $error("angle moved while selected");
    property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("bus not ready");
    property p_err; PSEL && !PENABLE && PADDR > 12'h018 |=> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("unmapped access not flagged");
    property p_start; FE_POWER_ON |-> seen; endproperty
    a_start: assert property (p_start) else $error("powered before select seen high");
    property p_drain; FE_POWER_ON [*3] |-> RAW_READY; endproperty
    a_drain: assert property (p_drain) else $error("buffer stuck full while powered");
    c_full: cover property ($fell(RAW_READY));
    c_down: cover property ($fell(FE_POWER_ON));
    c_err: cover property (PSLVERR);
endmodule
bind aps_core aps_core_props aps_core_props_i (.REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PADDR, .PREADY, .PSLVERR,
    .CS_N, .FE_POWER_ON, .FE_SAMPLE, .RAW_READY, .ANGLE, .ANGLE_UPDATE);

// File: tb/aps_fe_model.sv
module aps_fe_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample,
    input wire logic flood,
    input wire logic [15:0] code,
    input wire logic ready,
    output logic [15:0] raw,
    output logic valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // A word is held until taken; an idle bus inverts its data every cycle instead of holding the last code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            raw <= 16'h0000;
        end else if (!valid || ready) begin
            valid <= sample | flood;
            raw <= (sample | flood) ? code : ~raw;
        end
    end
endmodule

// File: tb/tb_aps_core.sv
module tb_aps_core;
    import aps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, EN_PIN = 0, AUTO_DUTY_CYCLE_MODE = 0;
    logic CS_N = 0, PREADY, PSLVERR, FE_POWER_ON, FE_SAMPLE, RAW_VALID, RAW_READY, ANGLE_UPDATE, flood = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic [15:0] RAW_ANGLE, ANGLE, code = 16'h1234, a;
    logic er;
    int errors = 0, cmp_count = 0, n, pushes = 0, on_cnt = 0, p0;
    aps_core aps_core_i (.REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .EN_PIN, .AUTO_DUTY_CYCLE_MODE, .CS_N, .FE_POWER_ON, .FE_SAMPLE, .RAW_ANGLE, .RAW_VALID,
        .RAW_READY, .ANGLE, .ANGLE_UPDATE);
    aps_fe_model aps_fe_model_i (.clk(REF_CLK), .rst(SYS_RST), .sample(FE_SAMPLE), .flood, .code,
        .ready(RAW_READY), .raw(RAW_ANGLE), .valid(RAW_VALID));
    initial begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        pushes <= pushes + (RAW_VALID && RAW_READY);
        on_cnt <= on_cnt + FE_POWER_ON;
    end
    task automatic conclude;
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK);
    endtask
    // Bounded wait on update (s=0) or sample (s=1); n holds the cycles spent
    task automatic wt(input bit s);
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while ((s ? FE_SAMPLE : ANGLE_UPDATE) !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            errors++;
            conclude();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            conclude();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge REF_CLK);
    endtask
    task automatic s_start;
        cyc(50);
        chk(FE_POWER_ON, 0);
        apb(0, 12'h014, 0);
        chk(rd[4:0], 5'h01);
        CS_N <= 1;
        cyc(5);
        chk(FE_POWER_ON, 1);
    endtask
    task automatic s_regs;
        logic [11:0] ad[5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
        logic [31:0] ex[5] = '{32'h0, 32'h4, 32'h0, 32'h1, 32'ha};
        for (int i = 0; i < 5; i++) begin
            apb(0, ad[i], 0);
            chk(rd, ex[i]);
        end
        apb(0, 12'h01c, 0);
        chk(rd, 32'h0);
        chk(er, 1);
    endtask
    task automatic s_angle;
        logic [31:0] z[3] = '{32'h0, 32'h1300, 32'h1300};
        logic [31:0] c[3] = '{32'h0, 32'h0, 32'h8};
        logic [15:0] ex[3] = '{16'h1234, 16'hff34, 16'h00cc};
        apb(1, 12'h004, 0);
        for (int i = 0; i < 3; i++) begin
            apb(1, 12'h008, z[i]);
            apb(1, 12'h000, c[i]);
            wt(0);
            wt(0);
            chk(ANGLE, ex[i]);
        end
        apb(1, 12'h000, 0);
        apb(1, 12'h008, 0);
    endtask
    task automatic s_filter;
        apb(1, 12'h004, 1);
        wt(1);
        wt(1);
        chk(n, 40);
        code <= 16'h1300;
        wt(0);
        wt(0);
        chk(ANGLE, 16'h129a);
    endtask
    // Chip select low freezes the offered angle; the held update shows right after release
    task automatic s_hold;
        CS_N <= 0;
        cyc(1);
        a = ANGLE;
        cyc(100);
        chk(ANGLE, a);
        CS_N <= 1;
        wt(0);
        chk(n, 2);
    endtask
    task automatic s_idle;
        // Enter idle just after a sample, so no word is in flight when the buffer stops draining
        wt(1);
        apb(1, 12'h000, 1);
        cyc(5);
        chk(FE_POWER_ON, 0);
        a = ANGLE;
        p0 = pushes;
        flood <= 1;
        cyc(30);
        chk(pushes - p0, 8);
        chk({RAW_READY, ANGLE}, {1'b0, a});
        flood <= 0;
        apb(1, 12'h000, 0);
        cyc(20);
        chk(RAW_READY, 1);
    endtask
    task automatic s_auto;
        apb(1, 12'h010, 3);
        apb(1, 12'h000, 2);
        wt(0);
        wt(0);
        p0 = on_cnt;
        wt(0);
        chk(n, 1200);
        chk(on_cnt - p0, 400);
        cyc(2);
        chk(FE_POWER_ON, 0);
        apb(0, 12'h018, 0);
        chk(rd, {16'h0, ANGLE});
    endtask
    task automatic s_pins;
        apb(1, 12'h000, 4);
        cyc(5);
        chk(FE_POWER_ON, 0);
        EN_PIN <= 1;
        cyc(5);
        p0 = on_cnt;
        cyc(1300);
        chk(on_cnt - p0, 1300);
        AUTO_DUTY_CYCLE_MODE <= 1;
        cyc(5);
        p0 = on_cnt;
        cyc(1300);
        chk((on_cnt - p0) < 1300, 1);
    endtask
    initial begin
        cyc(4);
        SYS_RST <= 0;
        s_start();
        s_regs();
        s_angle();
        s_filter();
        s_hold();
        s_idle();
        s_auto();
        s_pins();
        conclude();
    end
endmodule
